// ### logic/keypad_fan_command_handler.sv
// Keypad reporting, fan fail-safe and tachometer blanking command handler.
`timescale 1ns/1ns
`include "kf_map.svh"
module keypad_fan_command_handler
   import kf_pkg::*;
#(
   parameter int SLOT_CYC = `KF_SLOT_CYC,
   parameter int TICK_CYC = `KF_TICK_CYC
)
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic CMD_VALID,
   input wire cmd_s CMD,
   output logic RSP_VALID,
   output rsp_s RSP,
   input wire logic [5:0] KEY_PIN,
   output logic EVT_VALID,
   output logic [7:0] EVT_PRESSED,
   output logic [7:0] EVT_RELEASED,
   input wire logic CFG_SAVE,
   output logic CFG_SAVE_VALID,
   output cfg_s CFG_IMAGE,
   input wire logic CFG_LOAD,
   input wire cfg_s CFG_BOOT,
   input wire logic FAN_SET_VALID,
   input wire fan_pwr_s FAN_SET,
   input wire logic [3:0] FAN_RPM_EN,
   output logic [3:0] FAN_ON,
   input wire logic [3:0] TACH_PIN,
   output logic [3:0] TACH_PULSE,
   output fan_pwr_s FAN_POWER,
   output logic [3:0] FAILSAFE_FORCED
);
   localparam int SW = $clog2(SLOT_CYC + 1);
   localparam int TW = $clog2(TICK_CYC + 1);

   logic [5:0] key_s1_reg, key_s2_reg, key_s3_reg, key_state_reg;
   logic [5:0] acc_press_reg, acc_release_reg;
   cfg_s cfg_reg;
   fan_pwr_s power_reg;
   logic [3:0] fs_mask_reg, forced_reg;
   logic [7:0] fs_reload_reg, fs_cnt_reg;
   logic [TW-1:0] tick_cnt_reg;
   logic [SW-1:0] slot_cnt_reg;
   logic [6:0] phase_reg;
   logic [3:0] fan_on_reg, tach_level_reg, tach_pulse_reg;
   logic [3:0] tach_s1_reg, tach_s2_reg, tach_s3_reg;
   logic [3:0][7:0] blank_reg;
   fan_pwr_s eff_reg;
   rsp_s rsp_reg;
   logic rsp_valid_reg, evt_valid_reg, save_valid_reg;
   logic [7:0] evt_press_reg, evt_release_reg;
   cfg_s image_reg;

   // A key level counts only once the last two synchroniser stages agree.
   wire [5:0] key_agree = ~(key_s2_reg ^ key_s3_reg);
   wire [5:0] key_next = (key_s3_reg & key_agree) | (key_state_reg & ~key_agree);
   wire [5:0] key_rise = key_next & ~key_state_reg;
   wire [5:0] key_fall = ~key_next & key_state_reg;

   wire is_key_cfg = CMD_VALID && CMD.kind == `KF_CMD_KEY_CFG;
   wire is_poll = CMD_VALID && CMD.kind == `KF_CMD_KEY_POLL;
   wire is_fs = CMD_VALID && CMD.kind == `KF_CMD_FAILSAFE;
   wire is_glitch = CMD_VALID && CMD.kind == `KF_CMD_GLITCH;
   wire is_query = CMD_VALID && CMD.kind == `KF_CMD_FAN_QUERY;
   wire fs_args_ok = CMD.data[0][7:4] == 4'h0 && CMD.data[0][3:0] != 4'h0 && CMD.data[1] != 8'h00;
   wire ok_key_cfg = is_key_cfg && CMD.len == 3'd2;
   wire ok_poll = is_poll && CMD.len == 3'd0;
   wire ok_fs = is_fs && CMD.len == 3'd2 && fs_args_ok;
   wire ok_glitch = is_glitch && CMD.len == 3'd4;
   wire ok_query = is_query && CMD.len == 3'd0;
   wire known = is_key_cfg || is_poll || is_fs || is_glitch || is_query;
   wire accepted = ok_key_cfg || ok_poll || ok_fs || ok_glitch || ok_query;

   wire tick_en = tick_cnt_reg == TW'(TICK_CYC - 1);
   wire slot_en = slot_cnt_reg == SW'(SLOT_CYC - 1);
   wire fs_restart = FAN_SET_VALID || ok_fs;
   wire fs_expire = tick_en && !fs_restart && fs_cnt_reg == 8'h01;

   // The reply is assembled from the state seen in the command's own cycle.
   rsp_s rsp_next;
   always_comb
   begin
      rsp_next = '0;
      rsp_next.kind = `KF_ACK_FLAG | CMD.kind;
      if (!accepted)
         rsp_next.kind = `KF_ERR_FLAG | {2'b00, CMD.kind[5:0]};
      else if (ok_poll)
      begin
         rsp_next.len = 3'd3; // RL5
         rsp_next.data[0] = {2'b00, key_state_reg}; // RL4
         rsp_next.data[1] = {2'b00, acc_press_reg}; // RL7
         rsp_next.data[2] = {2'b00, acc_release_reg}; // RL7
      end
      else if (ok_query)
      begin
         rsp_next.len = 3'd5; // RL21
         rsp_next.data[3:0] = power_reg.power;
         rsp_next.data[4] = {4'h0, fs_mask_reg};
      end
   end

   always_ff @(posedge MCLK)
   begin
      key_s1_reg <= KEY_PIN;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
      tach_s1_reg <= TACH_PIN;
      tach_s2_reg <= tach_s1_reg;
      tach_s3_reg <= tach_s2_reg;
   end

   // A key event in the poll cycle is kept, not swept away by the clear.
   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         key_state_reg <= 6'h00;
         acc_press_reg <= 6'h00;
         acc_release_reg <= 6'h00;
      end
      else
      begin
         key_state_reg <= key_next;
         acc_press_reg <= (ok_poll ? 6'h00 : acc_press_reg) | key_rise; // RL6
         acc_release_reg <= (ok_poll ? 6'h00 : acc_release_reg) | key_fall; // RL6
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         evt_valid_reg <= 1'b0;
         evt_press_reg <= 8'h00;
         evt_release_reg <= 8'h00;
      end
      else
      begin
         evt_press_reg <= {2'b00, key_rise} & cfg_reg.press_mask;
         evt_release_reg <= {2'b00, key_fall} & cfg_reg.release_mask;
         evt_valid_reg <= |(({2'b00, key_rise} & cfg_reg.press_mask)
                          | ({2'b00, key_fall} & cfg_reg.release_mask));
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         cfg_reg.press_mask <= `KF_KEY_ALL; // RL1
         cfg_reg.release_mask <= `KF_KEY_ALL; // RL1
         cfg_reg.glitch <= {4{`KF_GLITCH_RST}}; // RL17
      end
      else if (ok_key_cfg)
      begin
         cfg_reg.press_mask <= CMD.data[0]; // RL2
         cfg_reg.release_mask <= CMD.data[1]; // RL2
      end
      else if (ok_glitch)
      begin
         cfg_reg.glitch <= CMD.data; // RL18
      end
      else if (CFG_LOAD)
      begin
         cfg_reg <= CFG_BOOT;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         save_valid_reg <= 1'b0;
         image_reg <= '0;
         rsp_valid_reg <= 1'b0;
         rsp_reg <= '0;
      end
      else
      begin
         save_valid_reg <= CFG_SAVE;
         if (CFG_SAVE)
            image_reg <= cfg_reg; // RL3 RL19
         rsp_valid_reg <= known;
         if (known)
            rsp_reg <= rsp_next; // RL2 RL9 RL18
      end
   end

   // Fail-safe countdown; an expiry and a restart in one cycle favour the restart.
   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         tick_cnt_reg <= '0;
         fs_mask_reg <= 4'h0;
         fs_reload_reg <= 8'h00;
         fs_cnt_reg <= 8'h00;
         forced_reg <= 4'h0;
         power_reg.power <= {4{`KF_FAN_PWR_RST}};
      end
      else
      begin
         tick_cnt_reg <= (tick_en || fs_restart) ? '0 : tick_cnt_reg + 1'b1;
         if (FAN_SET_VALID)
            power_reg <= FAN_SET;
         if (ok_fs)
         begin
            fs_mask_reg <= CMD.data[0][3:0]; // RL9
            fs_reload_reg <= CMD.data[1]; // RL10
            fs_cnt_reg <= CMD.data[1]; // RL10
            forced_reg <= forced_reg & CMD.data[0][3:0];
         end
         else if (FAN_SET_VALID)
         begin
            fs_cnt_reg <= fs_reload_reg; // RL12
            forced_reg <= 4'h0; // RL12
         end
         else if (tick_en && fs_cnt_reg != 8'h00)
         begin
            fs_cnt_reg <= fs_cnt_reg - 8'h01;
            if (fs_expire)
               forced_reg <= forced_reg | fs_mask_reg; // RL11
         end
      end
   end

   // Each PWM period is one hundred glitch counts, close to 18 Hz.
   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         slot_cnt_reg <= '0;
         phase_reg <= 7'h00;
      end
      else
      begin
         slot_cnt_reg <= slot_en ? '0 : slot_cnt_reg + 1'b1; // RL16
         if (slot_en)
            phase_reg <= (phase_reg == `KF_PWM_SLOTS - 7'h01) ? 7'h00 : phase_reg + 7'h01; // RL14
      end
   end

   genvar f;
   generate
      for (f = 0; f < 4; f++)
      begin : fan
         wire [7:0] eff = forced_reg[f] ? `KF_FULL_POWER : power_reg.power[f]; // RL11
         // Fans with RPM reporting keep a short on window so the tach is seen at 0%.
         wire on_next = eff >= `KF_FULL_POWER || {1'b0, phase_reg} < eff
                        || (FAN_RPM_EN[f] && {1'b0, phase_reg} <= cfg_reg.glitch[f]); // RL20
         wire tach_agree = tach_s2_reg[f] == tach_s3_reg[f];
         wire tach_rise = tach_agree && tach_s3_reg[f] && !tach_level_reg[f];
         always_ff @(posedge MCLK)
         begin
            if (RESET)
            begin
               fan_on_reg[f] <= 1'b0;
               blank_reg[f] <= 8'h00;
               tach_level_reg[f] <= 1'b0;
               tach_pulse_reg[f] <= 1'b0;
               eff_reg.power[f] <= 8'h00;
            end
            else
            begin
               eff_reg.power[f] <= eff;
               if (tach_agree)
                  tach_level_reg[f] <= tach_s3_reg[f];
               tach_pulse_reg[f] <= tach_rise && fan_on_reg[f] && blank_reg[f] == 8'h00; // RL15
               if (slot_en)
               begin
                  fan_on_reg[f] <= on_next; // RL14
                  if (on_next && !fan_on_reg[f])
                  begin
                     blank_reg[f] <= cfg_reg.glitch[f]; // RL15
                  end
                  else if (blank_reg[f] != 8'h00)
                  begin
                     blank_reg[f] <= blank_reg[f] - 8'h01;
                  end
               end
            end
         end
         a_forced_full: assert property (@(posedge MCLK) disable iff (RESET)
            forced_reg[f] |=> eff_reg.power[f] == `KF_FULL_POWER) // RL11
            else $error("forced fan not at full power");
         a_tach_blank: assert property (@(posedge MCLK) disable iff (RESET)
            blank_reg[f] != 8'h00 |=> !tach_pulse_reg[f]) // RL15
            else $error("tach pulse during blanking");
      end
   endgenerate

   assign RSP_VALID = rsp_valid_reg;
   assign RSP = rsp_reg;
   assign EVT_VALID = evt_valid_reg;
   assign EVT_PRESSED = evt_press_reg;
   assign EVT_RELEASED = evt_release_reg;
   assign CFG_SAVE_VALID = save_valid_reg;
   assign CFG_IMAGE = image_reg;
   assign FAN_ON = fan_on_reg;
   assign TACH_PULSE = tach_pulse_reg;
   assign FAN_POWER = eff_reg;
   assign FAILSAFE_FORCED = forced_reg;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   a_poll_reply: assert property (ok_poll |=> RSP_VALID && RSP.kind == 8'h58 && RSP.len == 3'd3
      && RSP.data[0] == {2'b00, $past(key_state_reg)}) // RL5
      else $error("poll reply wrong");
   a_poll_clear: assert property (ok_poll && key_rise == 6'h00 |=> acc_press_reg == 6'h00) // RL6
      else $error("pressed mask not cleared by poll");
   a_key_cfg: assert property (ok_key_cfg |=> RSP.kind == 8'h57 && RSP.len == 3'd0
      && cfg_reg.press_mask == $past(CMD.data[0])) // RL2
      else $error("key config not applied");
   a_save_image: assert property (CFG_SAVE |=> CFG_SAVE_VALID
      && CFG_IMAGE.glitch == $past(cfg_reg.glitch)) // RL19
      else $error("boot image misses settings");
   a_fs_restart: assert property (FAN_SET_VALID && !ok_fs |=> fs_cnt_reg == $past(fs_reload_reg)
      && FAILSAFE_FORCED == 4'h0) // RL12
      else $error("fail-safe not restarted");
   a_fs_expire: assert property (fs_expire |=> (FAILSAFE_FORCED & fs_mask_reg) == fs_mask_reg) // RL11
      else $error("fail-safe expiry missed");
   a_glitch_load: assert property (ok_glitch |=> cfg_reg.glitch[3] == $past(CMD.data[3])
      && RSP.kind == 8'h5a) // RL18
      else $error("glitch delays not loaded");
   a_fan_query: assert property (ok_query |=> RSP.len == 3'd5
      && RSP.data[4] == {4'h0, $past(fs_mask_reg)}) // RL21
      else $error("fan query reply wrong");
   a_fs_arm: assert property (ok_fs |=> fs_cnt_reg == $past(CMD.data[1]) && RSP.kind == 8'h59) // RL10
      else $error("fail-safe not armed");

   c_poll: cover property (ok_poll ##1 RSP.data[1] != 8'h00);
   c_expire: cover property (fs_expire ##1 FAILSAFE_FORCED != 4'h0);
   c_tach: cover property (TACH_PULSE != 4'h0);
   c_event: cover property (EVT_VALID);
endmodule : keypad_fan_command_handler

// ### logic/kf_map.svh
// Constants of the keypad and fan command handler.
// Overview of operation
// RL1 - Without boot settings, report every key event.
// RL2 - Command 0x17 loads press/release masks, acks 0x57.
// RL3 - Press and release masks belong to boot image.
// RL4 - One bit per key; poll byte0 holds keys down.
// RL5 - Command 0x18 replies 0x58 with three bytes.
// RL6 - A poll clears the pressed/released accumulators.
// RL7 - Poll sees all keys, masks ignored.
// RL8 - Polling host should zero both reporting masks.
// RL9 - Command 0x19 takes fan mask 1-15, acks 0x59.
// RL10 - Byte1 sets timeout in eighth-second ticks, 1-255.
// RL11 - On timeout, masked fans run full power.
// RL12 - Each fan power update restarts the countdown.
// RL13 - Host software arms fail-safe when it starts.
// RL14 - Fans are switched by PWM near 18 Hz.
// RL15 - Tach ignored for glitch delay after turn-on.
// RL16 - One glitch count is 552.5 us, PWM/100.
// RL17 - Each glitch delay defaults to one count.
// RL18 - Command 0x1A loads four delays, acks 0x5A.
// RL19 - Glitch delays belong to boot image.
// RL20 - Larger delays raise minimum speed with RPM reporting.
// RL21 - Command 0x1B replies 0x5B with powers and mask.
`ifndef KF_MAP_SVH
`define KF_MAP_SVH
`define KF_CMD_KEY_CFG 8'h17
`define KF_CMD_KEY_POLL 8'h18
`define KF_CMD_FAILSAFE 8'h19
`define KF_CMD_GLITCH 8'h1a
`define KF_CMD_FAN_QUERY 8'h1b
`define KF_ACK_FLAG 8'h40
`define KF_ERR_FLAG 8'hc0
`define KF_KEY_ALL 8'h3f
`define KF_FAN_ALL 4'hf
`define KF_GLITCH_RST 8'h01
`define KF_FAN_PWR_RST 8'h64
`define KF_FULL_POWER 8'h64
`define KF_PWM_SLOTS 7'h64
`define KF_CLK_NS 4
`define KF_SLOT_NS 552500
`define KF_TICK_NS 125000000
`define KF_SLOT_CYC (`KF_SLOT_NS / `KF_CLK_NS)
`define KF_TICK_CYC (`KF_TICK_NS / `KF_CLK_NS)
`endif

// ### logic/kf_pkg.sv
// Types shared by the keypad and fan command handler.
package kf_pkg;
   typedef struct packed
   {
      logic [7:0] kind;
      logic [2:0] len;
      logic [3:0][7:0] data;
   } cmd_s;
   typedef struct packed
   {
      logic [7:0] kind;
      logic [2:0] len;
      logic [4:0][7:0] data;
   } rsp_s;
   typedef struct packed
   {
      logic [7:0] press_mask;
      logic [7:0] release_mask;
      logic [3:0][7:0] glitch;
   } cfg_s;
   typedef struct packed
   {
      logic [3:0][7:0] power;
   } fan_pwr_s;
endpackage : kf_pkg

// ### tb/kf_host.sv
// Host-side model that sends command packets and captures the replies.
`timescale 1ns/1ns
module kf_host
   import kf_pkg::*;
(
   input wire logic MCLK,
   input wire logic RSP_VALID,
   input wire rsp_s RSP,
   output logic CMD_VALID,
   output cmd_s CMD
);
   rsp_s last_rsp;
   logic got;
   initial
   begin
      CMD_VALID = 1'b0;
      CMD = '0;
      got = 1'b0;
      last_rsp = '0;
   end
   // The bench decides when fail-safe is armed and when both report masks go to zero.
   task send(input logic [7:0] kind, input logic [2:0] len, input logic [31:0] data);
   begin
      @(posedge MCLK);
      CMD_VALID <= 1'b1;
      CMD <= '{kind: kind, len: len, data: data};
      @(posedge MCLK);
      CMD_VALID <= 1'b0;
      // Released lines carry a changed pattern so stale bytes cannot pass for a command.
      CMD <= ~CMD;
      #1;
      got = RSP_VALID;
      last_rsp = RSP;
   end
   endtask : send
endmodule : kf_host

// ### tb/tb_keypad_fan_command_handler.sv
// Self-checking bench for the keypad and fan command handler.
`timescale 1ns/1ns
module tb_keypad_fan_command_handler
   import kf_pkg::*;
   ;
   logic mclk, rst, cmd_valid, rsp_valid, evt_valid, cfg_save, cfg_save_valid, fan_set_valid;
   cmd_s cmd;
   rsp_s rsp;
   logic [5:0] key_pin;
   logic [7:0] evt_pressed, evt_released;
   logic cfg_load;
   cfg_s cfg_image, cfg_boot;
   fan_pwr_s fan_set, fan_power;
   logic [3:0] fan_on, forced, rpm_en, tach_pin, tach_pulse;
   logic [63:0] seen;
   int errors, total_checks, n, k;
   int cnt [4];
   keypad_fan_command_handler #(.SLOT_CYC(4), .TICK_CYC(20)) dut (.MCLK(mclk), .RESET(rst),
      .CMD_VALID(cmd_valid), .CMD(cmd), .RSP_VALID(rsp_valid), .RSP(rsp), .KEY_PIN(key_pin),
      .EVT_VALID(evt_valid), .EVT_PRESSED(evt_pressed), .EVT_RELEASED(evt_released),
      .CFG_SAVE(cfg_save), .CFG_SAVE_VALID(cfg_save_valid), .CFG_IMAGE(cfg_image),
      .CFG_LOAD(cfg_load), .CFG_BOOT(cfg_boot), .FAN_SET_VALID(fan_set_valid), .FAN_SET(fan_set),
      .FAN_RPM_EN(rpm_en), .FAN_ON(fan_on), .TACH_PIN(tach_pin), .TACH_PULSE(tach_pulse),
      .FAN_POWER(fan_power), .FAILSAFE_FORCED(forced));
   kf_host host (.MCLK(mclk), .RSP_VALID(rsp_valid), .RSP(rsp), .CMD_VALID(cmd_valid),
      .CMD(cmd));
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task give_verdict;
   begin
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask : give_verdict
   task chk(input logic [63:0] got, input logic [63:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   end
   endtask : chk
   task do_cmd(input logic [7:0] kind, input logic [2:0] len, input logic [31:0] data,
      input logic [7:0] ekind, input logic [2:0] elen);
   begin
      host.send(kind, len, data);
      chk({host.got, host.last_rsp.kind, host.last_rsp.len}, {1'b1, ekind, elen});
   end
   endtask : do_cmd
   task save_chk(input logic [47:0] exp);
   begin
      @(posedge mclk);
      cfg_save <= 1'b1;
      @(posedge mclk);
      cfg_save <= 1'b0;
      #1;
      chk({cfg_save_valid, cfg_image}, {1'b1, exp});
   end
   endtask : save_chk
   task fan_pulse(input logic [31:0] p);
   begin
      @(posedge mclk);
      fan_set_valid <= 1'b1;
      fan_set <= p;
      @(posedge mclk);
      fan_set_valid <= 1'b0;
      #1;
   end
   endtask : fan_pulse
   // Waits for a key report; a missing report ends the run.
   task wait_evt;
   begin
      for (n = 0; n < 12 && evt_valid !== 1'b1; n++)
      begin
         @(posedge mclk);
         #1;
      end
      if (evt_valid !== 1'b1)
      begin
         errors++;
         give_verdict;
      end
   end
   endtask : wait_evt
   task quiet_wait(input int cyc);
   begin
      n = 0;
      repeat (cyc)
      begin
         @(posedge mclk);
         #1;
         if (evt_valid !== 1'b0)
            n++;
      end
   end
   endtask : quiet_wait
   // Counts per fan the cycles with supply on or a tach pulse; an unknown counts 1000.
   task count_fans(input int cyc, input logic use_tach);
   begin
      logic sel;
      for (k = 0; k < 4; k++)
         cnt[k] = 0;
      repeat (cyc)
      begin
         @(posedge mclk);
         #1;
         for (k = 0; k < 4; k++)
         begin
            sel = use_tach ? tach_pulse[k] : fan_on[k];
            cnt[k] += (sel === 1'b1) ? 1 : ((sel === 1'b0) ? 0 : 1000);
         end
      end
      seen = {16'(cnt[3]), 16'(cnt[2]), 16'(cnt[1]), 16'(cnt[0])};
   end
   endtask : count_fans
   initial
   begin
      repeat (20000) @(posedge mclk);
      errors++;
      give_verdict;
   end
   initial
   begin
      errors = 0;
      total_checks = 0;
      rst = 1'b1;
      key_pin = 6'h00;
      cfg_save = 1'b0;
      fan_set_valid = 1'b0;
      fan_set = '0;
      cfg_load = 1'b0;
      cfg_boot = '0;
      rpm_en = 4'h0;
      tach_pin = 4'h0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      chk(fan_on, 4'hf);
      save_chk({8'h3f, 8'h3f, 32'h01010101});
      do_cmd(8'h1b, 3'd0, 32'h0, 8'h5b, 3'd5);
      chk(host.last_rsp.data, 40'h0064646464);
      $display("test defaults done");
      @(posedge mclk);
      key_pin <= 6'h02;
      wait_evt;
      chk({evt_pressed, evt_released}, 16'h0200);
      do_cmd(8'h18, 3'd0, 32'h0, 8'h58, 3'd3);
      chk(host.last_rsp.data[2:0], 24'h000202);
      do_cmd(8'h18, 3'd0, 32'h0, 8'h58, 3'd3);
      chk(host.last_rsp.data[2:0], 24'h000002);
      @(posedge mclk);
      key_pin <= 6'h00;
      wait_evt;
      chk({evt_pressed, evt_released}, 16'h0002);
      do_cmd(8'h18, 3'd0, 32'h0, 8'h58, 3'd3);
      chk(host.last_rsp.data[2:0], 24'h020000);
      $display("test events done");
      do_cmd(8'h17, 3'd2, 32'h0, 8'h57, 3'd0);
      for (k = 0; k < 6; k++)
      begin
         @(posedge mclk);
         key_pin <= 6'h01 << k;
         quiet_wait(8);
         chk(n, 0);
         do_cmd(8'h18, 3'd0, 32'h0, 8'h58, 3'd3);
         chk(host.last_rsp.data[1:0], {2{8'h01 << k}});
         @(posedge mclk);
         key_pin <= 6'h00;
         quiet_wait(8);
      end
      $display("test polling done");
      do_cmd(8'h1a, 3'd4, 32'h04030201, 8'h5a, 3'd0);
      save_chk({8'h00, 8'h00, 32'h04030201});
      do_cmd(8'h19, 3'd2, 32'h0210, 8'hd9, 3'd0);
      $display("test glitch done");
      fan_pulse(32'h0);
      do_cmd(8'h19, 3'd2, 32'h0205, 8'h59, 3'd0);
      // Two ticks of twenty cycles run from the edge that takes the command.
      repeat (39) @(posedge mclk);
      #1;
      chk(forced, 4'h0);
      @(posedge mclk);
      #1;
      chk(forced, 4'h5);
      @(posedge mclk);
      #1;
      chk(fan_power, 32'h00640064);
      do_cmd(8'h1b, 3'd0, 32'h0, 8'h5b, 3'd5);
      chk(host.last_rsp.data[4], 8'h05);
      fan_pulse(32'h0);
      @(posedge mclk);
      #1;
      chk(forced, 4'h0);
      $display("test failsafe done");
      @(posedge mclk);
      rpm_en <= 4'ha;
      repeat (400) @(posedge mclk);
      count_fans(400, 1'b0);
      chk(seen, 64'h00140190000c0190);
      @(posedge mclk);
      rpm_en <= 4'h0;
      repeat (8) @(posedge mclk);
      tach_pin <= 4'hf;
      count_fans(12, 1'b1);
      chk(seen, 64'h0000000100000001);
      $display("test fans done");
      @(posedge mclk);
      cfg_load <= 1'b1;
      cfg_boot <= {8'h01, 8'h00, 32'h05050505};
      @(posedge mclk);
      cfg_load <= 1'b0;
      save_chk({8'h01, 8'h00, 32'h05050505});
      @(posedge mclk);
      key_pin <= 6'h03;
      wait_evt;
      chk({evt_pressed, evt_released}, 16'h0100);
      @(posedge mclk);
      key_pin <= 6'h00;
      quiet_wait(8);
      chk(n, 32'h0);
      $display("test boot load done");
      give_verdict;
   end
endmodule : tb_keypad_fan_command_handler
